/* File: hdl/acr_pkg.sv */
// constants, field positions and types shared by the converter control block
package acr_pkg;

	// ****************************************
	// register indices (byte address = 4 * index)
	// ****************************************
	localparam logic [7:0] ACR_IDX_RESULT_LOW = 8'h78;
	localparam logic [7:0] ACR_IDX_RESULT_HIGH = 8'h79;
	localparam logic [7:0] ACR_IDX_CTRL_STATUS = 8'h7a;
	localparam logic [7:0] ACR_IDX_CTRL_B = 8'h7b;
	localparam logic [7:0] ACR_IDX_INPUT_REF = 8'h7c;
	localparam int ACR_IDX_LSB = 2;

	// ****************************************
	// input_and_reference_select fields
	// ****************************************
	localparam int ACR_REF_BIT = 6;
	localparam int ACR_ALIGN_BIT = 5;
	localparam int ACR_CHAN_LSB = 0;
	localparam int ACR_CHAN_W = 4;
	localparam logic [7:0] ACR_INPUT_REF_MASK = 8'h6f;
	localparam logic [7:0] ACR_INPUT_REF_RESET = 8'h00;

	// ****************************************
	// converter_control_status fields
	// ****************************************
	localparam int ACR_EN_BIT = 7;
	localparam int ACR_START_BIT = 6;
	localparam int ACR_AUTO_BIT = 5;
	localparam int ACR_DONE_BIT = 4;
	localparam int ACR_IE_BIT = 3;
	localparam int ACR_DIV_LSB = 0;
	localparam int ACR_DIV_W = 3;
	localparam logic [7:0] ACR_CTRL_RESET = 8'h00;

	// ****************************************
	// converter_control_b fields
	// ****************************************
	localparam int ACR_TRIG_LSB = 0;
	localparam int ACR_TRIG_W = 3;
	localparam logic [2:0] ACR_TRIG_FREE_RUN = 3'h0;
	localparam int ACR_TRIG_SOURCES = 7;

	// ****************************************
	// channel codes
	// ****************************************
	localparam logic [3:0] ACR_CHAN_TEMP = 4'h8;
	localparam logic [3:0] ACR_CHAN_BANDGAP = 4'he;
	localparam logic [3:0] ACR_CHAN_GROUND = 4'hf;
	localparam int ACR_EXT_INPUTS = 8;

	// ****************************************
	// conversion timing in converter clock cycles, result width and prescaler counter width
	// ****************************************
	localparam logic [4:0] ACR_FIRST_CYCLES = 5'd25;
	localparam logic [4:0] ACR_NORMAL_CYCLES = 5'd13;
	localparam int ACR_RESULT_W = 10;
	localparam int ACR_PRESC_W = 7;

	// ****************************************
	// conversion state
	// ****************************************
	typedef enum logic [1:0] {
		ACR_IDLE = 2'b01,
		ACR_CONV = 2'b10
	} acr_state_e;

endpackage

/* File: hdl/acr_control.sv */
// converter control, prescaler and result registers behind an avalon-mm slave
// How it works
// - channel codes: 0-7 external inputs, 8 temperature, e bandgap, f ground, rest none.
// - temperature sensor is on whenever the channel field holds code 8.
// - bits 7 and 4 of the input select register always read zero.
// - reference bit 6: zero picks internal 1.1V, one picks analog supply.
// - a reference change during conversion applies once that conversion completes.
// - a channel change during conversion applies once that conversion completes.
// - alignment bit one: high byte result 9..2, low byte 1..0 at top.
// - alignment bit zero: low byte result 7..0, high byte 9..8 at bottom.
// - the alignment bit reorders visible result bytes at once, any time.
// - enable bit 7 turns the converter on; clearing it aborts a conversion.
// - writing one to start begins a conversion; free running needs it once.
// - first conversion after enable takes 25 converter cycles, later ones 13.
// - start reads one while converting, zero after; writing zero does nothing.
// - with auto trigger set, a rising edge of the chosen trigger starts one when idle.
// - done flag bit 4 sets when a conversion ends, whether or not the result is stored.
// - done flag clears on interrupt vector execution or when software writes one.
// - interrupt request is flag and enable bit 3 and global enable together.
// - divider codes 0,1 give 2; codes 2..7 give 4,8,16,32,64,128.
// - reading the low byte freezes the result until the high byte is read.
// - trigger source 0 is free running, 1..7 pick flag sources; needs auto.
//
// The Avalon-MM slave port was left to the implementer.
`timescale 1ns/1ps

module acr_control #(
	parameter int ADDR_W = 10
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic resetn,
	// avalon-mm slave
	input wire logic [ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [3:0] avs_byteenable,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// processor side
	input wire logic global_irq_enable,
	input wire logic irq_vector_ack,
	output logic conversion_irq,
	// trigger flags, bit n-1 is source n
	input wire logic [acr_pkg::ACR_TRIG_SOURCES-1:0] trigger_flags,
	// analog front end
	input wire logic [acr_pkg::ACR_RESULT_W-1:0] afe_result,
	output logic afe_enable,
	output logic afe_sample_start,
	output logic converter_tick,
	output logic [acr_pkg::ACR_EXT_INPUTS-1:0] ext_input_select,
	output logic temp_channel_select,
	output logic bandgap_select,
	output logic ground_select,
	output logic supply_reference,
	output logic temp_sensor_enable
);
	import acr_pkg::*;

	// ****************************************
	// registers
	// ****************************************
	acr_state_e state;
	logic ack;
	logic [7:0] input_ref;
	logic enable;
	logic auto_en;
	logic done_flag;
	logic irq_en;
	logic [2:0] divider;
	logic [2:0] trig_src;
	logic [ACR_CHAN_W-1:0] act_chan;
	logic act_ref;
	logic [ACR_RESULT_W-1:0] result;
	logic locked;
	logic first_pending;
	logic [ACR_PRESC_W-1:0] presc_cnt;
	logic [4:0] conv_cnt;
	logic [4:0] conv_len;
	logic trig_prev;

	// ****************************************
	// bus decode
	// ****************************************
	wire logic request = avs_read | avs_write;
	wire logic [7:0] idx = avs_address[ADDR_W-1:ACR_IDX_LSB];
	wire logic wr_fire = avs_write & ack & avs_byteenable[0];
	// read side effects act at the capture edge, so the lock and the low byte agree
	wire logic rd_fire = avs_read & ~ack;
	wire logic wr_ctrl = wr_fire & (idx == ACR_IDX_CTRL_STATUS);
	wire logic wr_ctrl_b = wr_fire & (idx == ACR_IDX_CTRL_B);
	wire logic wr_input = wr_fire & (idx == ACR_IDX_INPUT_REF);
	wire logic rd_low = rd_fire & (idx == ACR_IDX_RESULT_LOW);
	wire logic rd_high = rd_fire & (idx == ACR_IDX_RESULT_HIGH);
	wire logic [7:0] wd = avs_writedata[7:0];

	// one wait cycle per access, then the request is taken
	assign avs_waitrequest = request & ~ack;

	// ****************************************
	// prescaler
	// ****************************************
	wire logic [ACR_PRESC_W-1:0] presc_limit;
	// codes 0 and 1 both divide by two
	assign presc_limit = (divider <= 3'd1) ? 7'h01 :
		7'((8'h01 << divider) - 8'h01);
	wire logic tick = enable & (presc_cnt == presc_limit);
	assign converter_tick = tick;

	// ****************************************
	// control decode and conversion launch
	// ****************************************
	wire logic busy = (state == ACR_CONV);
	wire logic next_enable = wr_ctrl ? wd[ACR_EN_BIT] : enable;
	wire logic next_auto = wr_ctrl ? wd[ACR_AUTO_BIT] : auto_en;
	wire logic en_rise = next_enable & ~enable;
	// writing zero to start has no effect
	wire logic start_req = wr_ctrl & wd[ACR_START_BIT];
	wire logic done_pulse = busy & tick & (conv_cnt == conv_len - 5'd1);
	// trigger level of the chosen source; free running contributes no edge
	wire logic trig_level = (trig_src == ACR_TRIG_FREE_RUN) ? 1'b0 :
		trigger_flags[trig_src - 3'd1];
	wire logic trig_edge = trig_level & ~trig_prev;
	wire logic free_restart = auto_en & (trig_src == ACR_TRIG_FREE_RUN) & done_pulse;
	wire logic auto_start = auto_en & trig_edge;
	// a trigger while converting is dropped, not queued
	wire logic go = next_enable & ((~busy & (start_req | auto_start)) | free_restart);
	wire logic first_eff = first_pending | en_rise;

	// ****************************************
	// deferred channel and reference
	// ****************************************
	wire logic hold_act = busy & ~done_pulse;
	wire logic [ACR_CHAN_W-1:0] next_act_chan =
		hold_act ? act_chan : input_ref[ACR_CHAN_LSB +: ACR_CHAN_W];
	wire logic next_act_ref = hold_act ? act_ref : input_ref[ACR_REF_BIT];

	// ****************************************
	// flag and result
	// ****************************************
	wire logic flag_clr = (wr_ctrl & wd[ACR_DONE_BIT]) | irq_vector_ack;
	// set wins over a clear in the same cycle
	wire logic next_done = done_pulse | (done_flag & ~flag_clr);
	// a low byte capture in the same cycle already counts as held
	wire logic store = done_pulse & ~locked & ~rd_low;
	wire logic next_locked = rd_low ? 1'b1 : (rd_high ? 1'b0 : locked);

	// ****************************************
	// visible result bytes
	// ****************************************
	wire logic left = input_ref[ACR_ALIGN_BIT];
	wire logic [7:0] view_high = left ? result[9:2] : {6'h00, result[9:8]};
	wire logic [7:0] view_low = left ? {result[1:0], 6'h00} : result[7:0];
	wire logic [7:0] ctrl_view = {enable, busy, auto_en, done_flag, irq_en, divider};
	wire logic [7:0] rd_mux =
		(idx == ACR_IDX_RESULT_LOW) ? view_low :
		(idx == ACR_IDX_RESULT_HIGH) ? view_high :
		(idx == ACR_IDX_CTRL_STATUS) ? ctrl_view :
		(idx == ACR_IDX_CTRL_B) ? {5'h00, trig_src} :
		(idx == ACR_IDX_INPUT_REF) ? (input_ref & ACR_INPUT_REF_MASK) :
		8'h00;

	// ****************************************
	// outputs to the front end and processor
	// ****************************************
	assign conversion_irq = done_flag & irq_en & global_irq_enable;
	assign afe_enable = enable;
	assign supply_reference = act_ref;
	assign temp_sensor_enable =
		(input_ref[ACR_CHAN_LSB +: ACR_CHAN_W] == ACR_CHAN_TEMP);
	assign temp_channel_select = (act_chan == ACR_CHAN_TEMP);
	assign bandgap_select = (act_chan == ACR_CHAN_BANDGAP);
	assign ground_select = (act_chan == ACR_CHAN_GROUND);

	// one select line per external input
	genvar gi;
	generate
		for (gi = 0; gi < ACR_EXT_INPUTS; gi++) begin : g_ext
			assign ext_input_select[gi] =
				~act_chan[ACR_CHAN_W-1] & (act_chan[2:0] == 3'(gi));
		end
	endgenerate

	// ****************************************
	// bus slave
	// ****************************************
	// read data are captured in the wait cycle and stand at the taking edge
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			ack <= 1'b0;
			avs_readdata <= 32'h0000_0000;
		end else begin
			ack <= request & ~ack;
			if (avs_read & ~ack) begin
				avs_readdata <= {24'h00_0000, rd_mux};
			end
		end
	end

	// software written configuration
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			input_ref <= ACR_INPUT_REF_RESET;
			irq_en <= ACR_CTRL_RESET[ACR_IE_BIT];
			divider <= ACR_CTRL_RESET[ACR_DIV_LSB +: ACR_DIV_W];
			trig_src <= ACR_TRIG_FREE_RUN;
		end else begin
			if (wr_input) begin
				input_ref <= wd & ACR_INPUT_REF_MASK;
			end
			if (wr_ctrl) begin
				irq_en <= wd[ACR_IE_BIT];
				divider <= wd[ACR_DIV_LSB +: ACR_DIV_W];
			end
			if (wr_ctrl_b) begin
				trig_src <= wd[ACR_TRIG_LSB +: ACR_TRIG_W];
			end
		end
	end

	// enable, flags and deferred selection
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			enable <= 1'b0;
			auto_en <= 1'b0;
			done_flag <= 1'b0;
			locked <= 1'b0;
			act_chan <= 4'h0;
			act_ref <= 1'b0;
			trig_prev <= 1'b0;
		end else begin
			enable <= next_enable;
			auto_en <= next_auto;
			done_flag <= next_done;
			locked <= next_locked;
			act_chan <= next_act_chan;
			act_ref <= next_act_ref;
			trig_prev <= trig_level;
		end
	end

	// prescaler restarts from zero whenever the converter is off
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			presc_cnt <= 7'h00;
		end else if (!enable || tick) begin
			presc_cnt <= 7'h00;
		end else begin
			presc_cnt <= presc_cnt + 7'h01;
		end
	end

	// stored result; dropped while a low byte read holds it
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			result <= 10'h000;
		end else if (store) begin
			result <= afe_result;
		end
	end

	// ****************************************
	// conversion sequencer
	// ****************************************
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			state <= ACR_IDLE;
			conv_cnt <= 5'd0;
			conv_len <= ACR_NORMAL_CYCLES;
			first_pending <= 1'b0;
			afe_sample_start <= 1'b0;
		end else begin
			afe_sample_start <= go;
			if (!next_enable) begin
				state <= ACR_IDLE;
				first_pending <= 1'b0;
			end else if (go) begin
				state <= ACR_CONV;
				conv_cnt <= 5'd0;
				conv_len <= first_eff ? ACR_FIRST_CYCLES : ACR_NORMAL_CYCLES;
				first_pending <= 1'b0;
			end else begin
				first_pending <= first_eff;
				unique case (state)
					ACR_IDLE: begin
						conv_cnt <= 5'd0;
					end
					ACR_CONV: begin
						if (done_pulse) begin
							state <= ACR_IDLE;
						end else if (tick) begin
							conv_cnt <= conv_cnt + 5'd1;
						end
					end
					default: begin
						state <= ACR_IDLE;
					end
				endcase
			end
		end
	end

	// ****************************************
	// assertions
	// ****************************************
	sequence start_seq;
		go ##1 busy;
	endsequence

	sequence end_seq;
		done_pulse ##1 (done_flag && !busy || busy);
	endsequence

	logic rd_was_input;
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			rd_was_input <= 1'b0;
		end else begin
			rd_was_input <= avs_read & ~ack & (idx == ACR_IDX_INPUT_REF);
		end
	end

	reserved_zero_a: assert property (@(posedge ref_clk) disable iff (!resetn)
		rd_was_input |-> (avs_readdata[7] == 1'b0 && avs_readdata[4] == 1'b0))
		else $error("reserved input select bits read nonzero");

	temp_enable_a: assert property (@(posedge ref_clk) disable iff (!resetn)
		temp_sensor_enable == (input_ref[3:0] == ACR_CHAN_TEMP))
		else $error("temperature sensor enable wrong");

	left_align_a: assert property (@(posedge ref_clk) disable iff (!resetn)
		left |-> (view_high == result[9:2] && view_low[7:6] == result[1:0]))
		else $error("left aligned view wrong");

	right_align_a: assert property (@(posedge ref_clk) disable iff (!resetn)
		!left |-> (view_low == result[7:0] && view_high == {6'h00, result[9:8]}))
		else $error("right aligned view wrong");

	disable_abort_a: assert property (@(posedge ref_clk) disable iff (!resetn)
		(wr_ctrl && !wd[ACR_EN_BIT]) |=> (!busy && !enable))
		else $error("conversion not aborted on disable");

	start_busy_a: assert property (@(posedge ref_clk) disable iff (!resetn)
		(start_req && next_enable && !busy) |-> start_seq)
		else $error("start write did not begin a conversion");

	conv_length_a: assert property (@(posedge ref_clk) disable iff (!resetn)
		(go && first_eff) |=> (conv_len == ACR_FIRST_CYCLES))
		else $error("first conversion length wrong");

	flag_set_a: assert property (@(posedge ref_clk) disable iff (!resetn)
		done_pulse |-> end_seq ##0 done_flag)
		else $error("done flag not set at completion");

	flag_clear_a: assert property (@(posedge ref_clk) disable iff (!resetn)
		(irq_vector_ack && !done_pulse) |=> !done_flag)
		else $error("done flag not cleared by vector");

	irq_req_a: assert property (@(posedge ref_clk) disable iff (!resetn)
		conversion_irq == (done_flag && irq_en && global_irq_enable))
		else $error("interrupt request mismatch");

	defer_chan_a: assert property (@(posedge ref_clk) disable iff (!resetn)
		(busy && $past(busy) && !$past(done_pulse)) |-> ($stable(act_chan) && $stable(act_ref)))
		else $error("selection changed during conversion");

	presc_tick_a: assert property (@(posedge ref_clk) disable iff (!resetn)
		(tick && divider == 3'd7) |-> ($past(presc_cnt) == 7'd126))
		else $error("prescaler period wrong");

	result_lock_a: assert property (@(posedge ref_clk) disable iff (!resetn)
		(locked && !rd_high) |=> $stable(result))
		else $error("result changed while held");

endmodule

/* File: bench/acr_afe_model.sv */
// behavioural analog front end whose sample encodes the selected input
`timescale 1ns/1ps
module acr_afe_model (
	// clock and reset
	input wire logic ref_clk,
	input wire logic resetn,
	// control from the converter
	input wire logic afe_enable,
	input wire logic afe_sample_start,
	input wire logic [acr_pkg::ACR_EXT_INPUTS-1:0] ext_input_select,
	input wire logic temp_channel_select,
	input wire logic bandgap_select,
	input wire logic ground_select,
	input wire logic supply_reference,
	// sample back to the converter
	output logic [acr_pkg::ACR_RESULT_W-1:0] afe_result
);
	import acr_pkg::*;
	logic [3:0] chan;
	logic [9:0] held;
	// channel seen on the mux lines, 9 when nothing is connected
	always_comb begin
		chan = 4'h9;
		for (int i = 0; i < ACR_EXT_INPUTS; i++) begin
			if (ext_input_select[i]) chan = i[3:0];
		end
		if (temp_channel_select) chan = ACR_CHAN_TEMP;
		if (bandgap_select) chan = ACR_CHAN_BANDGAP;
		if (ground_select) chan = ACR_CHAN_GROUND;
	end
	// sampled at the start pulse; powered down the line shows junk, not the last value
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) held <= 10'h000;
		else if (afe_sample_start) held <= {supply_reference, chan, 5'h15};
		else if (!afe_enable) held <= ~held;
	end
	assign afe_result = held;
endmodule

/* File: bench/acr_control_tb.sv */
// self-checking bench for the converter control block
`timescale 1ns/1ps
module acr_control_tb;
	import acr_pkg::*;
	localparam logic [9:0] A_LO = {ACR_IDX_RESULT_LOW, 2'b00};
	localparam logic [9:0] A_HI = {ACR_IDX_RESULT_HIGH, 2'b00};
	localparam logic [9:0] A_CS = {ACR_IDX_CTRL_STATUS, 2'b00};
	localparam logic [9:0] A_TS = {ACR_IDX_CTRL_B, 2'b00};
	localparam logic [9:0] A_MX = {ACR_IDX_INPUT_REF, 2'b00};
	logic ref_clk = 1'b0;
	logic resetn = 1'b0;
	logic [9:0] avs_address = 10'h000;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [3:0] avs_byteenable = 4'h0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic global_irq_enable = 1'b0;
	logic irq_vector_ack = 1'b0;
	logic conversion_irq;
	logic [6:0] trigger_flags = 7'h00;
	logic [9:0] afe_result;
	logic afe_enable;
	logic afe_sample_start;
	logic converter_tick;
	logic [7:0] ext_input_select;
	logic temp_channel_select;
	logic bandgap_select;
	logic ground_select;
	logic supply_reference;
	logic temp_sensor_enable;
	int error_cnt = 0;
	int n_compared = 0;
	int ticks = 0;
	int cyc = 0;
	acr_control dut (.ref_clk(ref_clk), .resetn(resetn), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_byteenable(avs_byteenable),
		.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .global_irq_enable(global_irq_enable),
		.irq_vector_ack(irq_vector_ack), .conversion_irq(conversion_irq),
		.trigger_flags(trigger_flags), .afe_result(afe_result), .afe_enable(afe_enable),
		.afe_sample_start(afe_sample_start), .converter_tick(converter_tick),
		.ext_input_select(ext_input_select), .temp_channel_select(temp_channel_select),
		.bandgap_select(bandgap_select), .ground_select(ground_select),
		.supply_reference(supply_reference), .temp_sensor_enable(temp_sensor_enable));
	acr_afe_model afe (.ref_clk(ref_clk), .resetn(resetn), .afe_enable(afe_enable),
		.afe_sample_start(afe_sample_start), .ext_input_select(ext_input_select),
		.temp_channel_select(temp_channel_select), .bandgap_select(bandgap_select),
		.ground_select(ground_select), .supply_reference(supply_reference),
		.afe_result(afe_result));
	// 125 MHz clock
	initial begin
		forever #4 ref_clk = ~ref_clk;
	end
	// converter clock pulses and a hang limit well above the expected run
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (converter_tick === 1'b1) ticks <= ticks + 1;
		if (cyc == 30000) begin
			error_cnt++;
			results();
		end
	end
	task automatic results();
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		n_compared++;
		if (g !== e) begin
			$display("unexpected %s expected %h seen %h", nm, e, g);
			error_cnt++;
		end
	endtask
	// one avalon transfer; request held until waitrequest is seen low
	task automatic bus(input logic w, input logic [9:0] a, input logic [7:0] wd,
		output logic [7:0] rd);
		int n;
		n = 0;
		@(posedge ref_clk);
		avs_address <= a;
		avs_writedata <= {24'h0, wd};
		avs_byteenable <= 4'h1;
		avs_write <= w;
		avs_read <= ~w;
		// waitrequest and read data are looked at on the rising edge itself
		do begin
			@(posedge ref_clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 20);
		if (avs_waitrequest !== 1'b0) chk("waitrequest", 16'h0, 16'h1);
		rd = avs_readdata[7:0];
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	task automatic wr(input logic [9:0] a, input logic [7:0] d);
		logic [7:0] x;
		bus(1'b1, a, d, x);
	endtask
	task automatic rdchk(input logic [9:0] a, input logic [7:0] e, input string nm);
		logic [7:0] x;
		bus(1'b0, a, 8'h00, x);
		chk(nm, {8'h0, e}, {8'h0, x});
	endtask
	// polls the busy bit; returns the converter clock count since t0
	task automatic wait_idle(input int t0, output int n);
		logic [7:0] x;
		int k;
		k = 0;
		x = 8'h40;
		while (x[6] !== 1'b0 && k < 2000) begin
			bus(1'b0, A_CS, 8'h00, x);
			k++;
		end
		if (x[6] !== 1'b0) chk("idle wait", 16'h0, 16'h1);
		n = ticks - t0;
	endtask
	task automatic t_reset();
		logic [9:0] a [5] = '{A_LO, A_HI, A_CS, A_TS, A_MX};
		foreach (a[i]) rdchk(a[i], 8'h00, "reset value");
		wr(10'h3fc, 8'hff);
		rdchk(10'h3fc, 8'h00, "unmapped");
	endtask
	task automatic t_mux();
		logic [7:0] v;
		for (int c = 0; c < 16; c++) begin
			v = (c == 8) ? 8'h98 : (8'hd0 | c[7:0]);
			wr(A_MX, v);
			rdchk(A_MX, v & 8'h6f, "mux readback");
			chk("decode", {4'h0, (c < 8) ? 8'h01 << c : 8'h00, c == 8, c == 14, c == 15,
				v[6]}, {4'h0, ext_input_select, temp_channel_select, bandgap_select,
				ground_select, supply_reference});
			chk("temp enable", 16'(c == 8), 16'(temp_sensor_enable));
		end
	endtask
	// first conversion, deferred selection, alignment, result lock
	task automatic t_conv();
		logic [9:0] r;
		int t0;
		int n;
		r = {1'b1, 4'h3, 5'h15};
		wr(A_MX, 8'h43);
		wr(A_CS, 8'hc7);
		@(negedge ref_clk);
		t0 = ticks;
		chk("afe enable", 16'h1, 16'(afe_enable));
		rdchk(A_CS, 8'hc7, "busy");
		wr(A_MX, 8'h05);
		chk("held sel", 16'h108, {7'h0, supply_reference, ext_input_select});
		wait_idle(t0, n);
		chk("first length", 16'd25, 16'(n));
		rdchk(A_CS, 8'h97, "done set");
		chk("new sel", 16'h020, {7'h0, supply_reference, ext_input_select});
		rdchk(A_LO, r[7:0], "right low");
		rdchk(A_HI, {6'h0, r[9:8]}, "right high");
		wr(A_MX, 8'h25);
		rdchk(A_HI, r[9:2], "left high");
		rdchk(A_LO, {r[1:0], 6'h0}, "left low");
		wr(A_CS, 8'hd7);
		@(negedge ref_clk);
		t0 = ticks;
		rdchk(A_CS, 8'hc7, "done cleared");
		wait_idle(t0, n);
		chk("later length", 16'd13, 16'(n));
		rdchk(A_HI, r[9:2], "locked high");
	endtask
	task automatic t_irq();
		wr(A_CS, 8'h8f);
		global_irq_enable <= 1'b1;
		@(negedge ref_clk);
		chk("irq on", 16'h1, 16'(conversion_irq));
		@(posedge ref_clk);
		global_irq_enable <= 1'b0;
		@(negedge ref_clk);
		chk("irq global", 16'h0, 16'(conversion_irq));
		@(posedge ref_clk);
		irq_vector_ack <= 1'b1;
		@(posedge ref_clk);
		irq_vector_ack <= 1'b0;
		rdchk(A_CS, 8'h8f, "vector clear");
	endtask
	task automatic t_abort();
		wr(A_CS, 8'hc7);
		wr(A_CS, 8'h07);
		// the enable register settles after the taking edge
		@(negedge ref_clk);
		chk("afe off", 16'h0, 16'(afe_enable));
		rdchk(A_CS, 8'h07, "aborted");
	endtask
	// trigger edge start, start written as zero, then free running
	task automatic t_auto();
		int n;
		wr(A_TS, 8'h01);
		wr(A_CS, 8'ha0);
		@(posedge ref_clk);
		trigger_flags <= 7'h01;
		rdchk(A_CS, 8'he0, "trigger start");
		wait_idle(ticks, n);
		wr(A_CS, 8'hb0);
		rdchk(A_CS, 8'ha0, "still idle");
		wr(A_TS, 8'h00);
		wr(A_CS, 8'he0);
		repeat (40) @(posedge ref_clk);
		rdchk(A_CS, 8'hf0, "free running");
		wr(A_CS, 8'h10);
	endtask
	task automatic t_presc();
		int f [8] = '{2, 2, 4, 8, 16, 32, 64, 128};
		int n;
		for (int c = 0; c < 8; c++) begin
			wr(A_CS, 8'h80 | c[7:0]);
			n = 0;
			while (converter_tick !== 1'b1 && n < 300) begin
				@(negedge ref_clk);
				n++;
			end
			n = 0;
			do begin
				@(negedge ref_clk);
				n++;
			end while (converter_tick !== 1'b1 && n < 300);
			chk("tick period", 16'(f[c]), 16'(n));
		end
	endtask
	// main sequence
	initial begin
		repeat (6) @(posedge ref_clk);
		resetn <= 1'b1;
		t_reset();
		t_mux();
		t_conv();
		t_irq();
		t_abort();
		t_auto();
		t_presc();
		results();
	end
endmodule
